// ---- pkg/qstod_pkg.sv ----
// Purpose: constants and types for the quarter-second time-of-day counter
// Assumes: 32-bit axi4-lite register bus, 8-bit registers in the low byte
// Notes:   reference frequencies feed the 4 hz divider table
package qstod_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_MATCH   = 4'h8;
    localparam logic [3:0] OFS_COUNT   = 4'hc;

    // ==========================================================
    // control register fields
    localparam int CTL_ENABLE = 7;
    localparam int CTL_SRC_HI = 6;
    localparam int CTL_SRC_LO = 5;
    localparam int CTL_CLEAR  = 4;
    localparam int CTL_PS_HI  = 2;

    // ==========================================================
    // status register fields
    localparam int ST_QTICK_FLAG = 7;
    localparam int ST_SEC_FLAG   = 6;
    localparam int ST_HIT_FLAG   = 5;
    localparam int ST_QTICK_IE   = 4;
    localparam int ST_HIT_IE     = 2;
    localparam int ST_CMP_EN     = 1;
    localparam int ST_WR_PEND    = 0;
    localparam int MATCH_LO      = 2;

    // ==========================================================
    // reset values: external 32.768 khz oscillator
    localparam logic [1:0] SRC_OSC   = 2'h0;
    localparam logic [1:0] SRC_LPO   = 2'h1;
    localparam logic [1:0] SRC_IRC   = 2'h2;
    localparam logic [2:0] PS_RESET  = 3'h1;

    // ==========================================================
    // timing
    localparam int TICK_HZ           = 4;
    localparam int HZ_LPO            = 1000;
    localparam int HZ_32K768         = 32768;
    localparam int HZ_32K            = 32000;
    localparam int HZ_38K4           = 38400;
    localparam int HZ_4M9152         = 4915200;
    localparam int HZ_4M             = 4000000;
    localparam int HZ_8M             = 8000000;
    localparam int HZ_16M            = 16000000;
    localparam int DIV_W             = 22;
    // long enough that a back-to-back match write still sees pending set
    localparam logic [1:0] CMP_WR_CYCLES = 2'h3;

    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       enable;
        logic [1:0] source;
        logic [2:0] prescale;
    } qstod_ctrl_t;

    typedef struct packed {
        logic qtick;
        logic second;
        logic hit;
    } qstod_evt_t;

endpackage : qstod_pkg

// ---- hw/qstod_counter.sv ----
// Purpose: quarter-second time-of-day counter with axi4-lite registers
// Assumes: reference clocks are pins, synchronised here; core_clk 10 mhz
// Notes:   a reference must run below half of core_clk to be counted
//
// Functional notes
// - quarter tick sets status bit 7; writing 1 clears it
// - one-second condition sets status bit 6; writing 1 clears it
// - match condition sets status bit 5; writing 1 clears it
// - bit 4 enables an interrupt on every counter increment
// - bit 3 enables an interrupt on every fourth count
// - bit 2 gates the match interrupt; match needs function enabled
// - bit 1 enables the match function; clear means no match
// - bit 0 set by match write, clears when write completes
// - 6-bit match value in bits 7:2 compared to counter upper bits
// - match write loads bits 1:0 from counter low bits
// - enabled match sets hit flag and zeroes counter upper six bits
// - 8-bit counter from zero, wraps after all ones, 256 counts
// - counter advances once per 4 hz tick from source and prescaler
// - counter clear zeroes counter and the 4 hz generator
// - reset defaults suit an external 32.768 khz oscillator
// - while disabled counter and 4 hz generator held at zero
// - 3-bit prescaler picks divider; 000 for 1 khz, 001 for 32.768 khz
// - match output pulses on match regardless of interrupt enable
// - match write while pending bit set is ignored
module qstod_counter #(
    parameter logic [21:0] DIV_32K768 =
        22'(qstod_pkg::HZ_32K768 / qstod_pkg::TICK_HZ),
    parameter logic [21:0] DIV_32K    =
        22'(qstod_pkg::HZ_32K / qstod_pkg::TICK_HZ),
    parameter logic [21:0] DIV_38K4   =
        22'(qstod_pkg::HZ_38K4 / qstod_pkg::TICK_HZ),
    parameter logic [21:0] DIV_4M9152 =
        22'(qstod_pkg::HZ_4M9152 / qstod_pkg::TICK_HZ),
    parameter logic [21:0] DIV_4M     =
        22'(qstod_pkg::HZ_4M / qstod_pkg::TICK_HZ),
    parameter logic [21:0] DIV_8M     =
        22'(qstod_pkg::HZ_8M / qstod_pkg::TICK_HZ),
    parameter logic [21:0] DIV_16M    =
        22'(qstod_pkg::HZ_16M / qstod_pkg::TICK_HZ)
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        oscRefIn,
    input  wire logic        lowPowerOscIn,
    input  wire logic        intRefIn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             compareHitOut,
    output logic             irqReq
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    localparam logic [21:0] DIV_LPO =
        22'(qstod_pkg::HZ_LPO / qstod_pkg::TICK_HZ);

    // ==========================================================
    // reference synchronisers and edge detect
    logic [2:0]  refSync1_r;
    logic [2:0]  refSync2_r;
    logic        refLast_r;
    logic [2:0]  refPins;
    assign refPins = {intRefIn, lowPowerOscIn, oscRefIn};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge core_clk) begin
                refSync1_r[gi] <= rst ? 1'b0 : refPins[gi];
                refSync2_r[gi] <= rst ? 1'b0 : refSync1_r[gi];
            end
        end
    endgenerate

    // ==========================================================
    // registers
    qstod_pkg::qstod_ctrl_t ctrl_r;
    qstod_pkg::qstod_evt_t  flags_r;
    qstod_pkg::qstod_evt_t  ie_r;
    qstod_pkg::qstod_evt_t  flagSet;
    qstod_pkg::qstod_evt_t  flagClr;
    logic        cmpEn_r;
    logic [5:0]  cmpValue_r;
    logic [1:0]  cmpSnap_r;
    logic [1:0]  pendCnt_r;
    logic [7:0]  cnt_r;
    logic [7:0]  cntNxt;
    logic [7:0]  cntInc;
    logic [21:0] div_r;
    logic [21:0] divNxt;
    logic [21:0] divLimit;
    logic        refSel;
    logic        refEdge;
    logic        tick;
    logic        matchHit;
    logic        pending;
    logic        zeroAll;
    logic        clearReq;

    // ==========================================================
    // bus slave state
    logic [3:0]  awAddr_r;
    logic [7:0]  wByte_r;
    logic        wLane_r;
    logic        wrFire;
    logic        wrCtl;
    logic        wrSts;
    logic        wrMatch;
    logic        wrMapped;
    logic        rdMapped;
    logic [7:0]  rdMux;
    logic [7:0]  statusByte;

    // an unsupported source code yields no edges, so the counter stalls
    assign refSel = (ctrl_r.source == qstod_pkg::SRC_OSC) ? refSync2_r[0]
                  : (ctrl_r.source == qstod_pkg::SRC_LPO) ? refSync2_r[1]
                  : (ctrl_r.source == qstod_pkg::SRC_IRC) ? refSync2_r[2]
                  : 1'b0;
    assign refEdge = refSel & ~refLast_r;

    assign divLimit = (ctrl_r.prescale == 3'h0) ? DIV_LPO
                    : (ctrl_r.prescale == 3'h1) ? DIV_32K768
                    : (ctrl_r.prescale == 3'h2) ? DIV_32K
                    : (ctrl_r.prescale == 3'h3) ? DIV_38K4
                    : (ctrl_r.prescale == 3'h4) ? DIV_4M9152
                    : (ctrl_r.prescale == 3'h5) ? DIV_4M
                    : (ctrl_r.prescale == 3'h6) ? DIV_8M
                    : DIV_16M;

    // ==========================================================
    // write decode
    assign wrFire   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wrCtl    = wrFire & wLane_r & (awAddr_r == qstod_pkg::OFS_CONTROL);
    assign wrSts    = wrFire & wLane_r & (awAddr_r == qstod_pkg::OFS_STATUS);
    assign wrMatch  = wrFire & wLane_r & (awAddr_r == qstod_pkg::OFS_MATCH);
    assign wrMapped = (awAddr_r == qstod_pkg::OFS_CONTROL)
                    | (awAddr_r == qstod_pkg::OFS_STATUS)
                    | (awAddr_r == qstod_pkg::OFS_MATCH)
                    | (awAddr_r == qstod_pkg::OFS_COUNT);
    assign clearReq = wrCtl & wByte_r[qstod_pkg::CTL_CLEAR];

    // ==========================================================
    // 4 hz generator and counter
    assign pending  = (pendCnt_r != 2'h0);
    assign zeroAll  = ~ctrl_r.enable | clearReq;
    assign tick     = ctrl_r.enable & refEdge & (div_r == divLimit - 22'h1);
    assign cntInc   = 8'(cnt_r + 8'h01);
    // compare the full next count so the hit lands on the snapped quarter
    assign matchHit = tick & cmpEn_r & ~pending
                    & (cntInc == {cmpValue_r, cmpSnap_r});
    assign divNxt   = zeroAll ? 22'h0
                    : (tick ? 22'h0
                    : (refEdge ? 22'(div_r + 22'h1) : div_r));
    assign cntNxt   = zeroAll ? 8'h00
                    : matchHit ? {6'h00, cntInc[1:0]}
                    : tick ? cntInc : cnt_r;

    assign flagSet.qtick  = tick;
    assign flagSet.second = tick & (cntInc[1:0] == 2'h0);
    assign flagSet.hit    = matchHit;
    assign flagClr = wrSts ? wByte_r[qstod_pkg::ST_QTICK_FLAG:
                                     qstod_pkg::ST_HIT_FLAG] : 3'h0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            refLast_r <= 1'b0;
            div_r     <= 22'h0;
            cnt_r     <= 8'h00;
            flags_r   <= 3'h0;
        end else begin
            refLast_r <= refSel;
            div_r     <= divNxt;
            cnt_r     <= cntNxt;
            // a new event wins over a same-cycle clear
            flags_r   <= flagSet | (flags_r & ~flagClr);
        end
    end

    // ==========================================================
    // control, enables and compare value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r.enable   <= 1'b0;
            ctrl_r.source   <= qstod_pkg::SRC_OSC;
            ctrl_r.prescale <= qstod_pkg::PS_RESET;
            ie_r            <= 3'h0;
            cmpEn_r         <= 1'b0;
            cmpValue_r      <= 6'h00;
            cmpSnap_r       <= 2'h0;
            pendCnt_r       <= 2'h0;
        end else begin
            if (wrCtl) begin
                // source and prescale are expected to change only when off
                ctrl_r.enable   <= wByte_r[qstod_pkg::CTL_ENABLE];
                ctrl_r.source   <= wByte_r[qstod_pkg::CTL_SRC_HI:
                                           qstod_pkg::CTL_SRC_LO];
                ctrl_r.prescale <= wByte_r[qstod_pkg::CTL_PS_HI:0];
            end
            if (wrSts) begin
                ie_r    <= wByte_r[qstod_pkg::ST_QTICK_IE:
                                   qstod_pkg::ST_HIT_IE];
                cmpEn_r <= wByte_r[qstod_pkg::ST_CMP_EN];
            end
            if (wrMatch && !pending) begin
                cmpValue_r <= wByte_r[7:qstod_pkg::MATCH_LO];
                cmpSnap_r  <= cntNxt[1:0];
                pendCnt_r  <= qstod_pkg::CMP_WR_CYCLES;
            end else if (pending) begin
                pendCnt_r  <= 2'(pendCnt_r - 2'h1);
            end
        end
    end

    // ==========================================================
    // outputs to the system
    always_ff @(posedge core_clk) begin
        if (rst) begin
            compareHitOut <= 1'b0;
            irqReq        <= 1'b0;
        end else begin
            compareHitOut <= matchHit;
            irqReq        <= |(flags_r & ie_r);
        end
    end

    // ==========================================================
    // axi4-lite write channels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= qstod_pkg::RESP_OKAY;
            awAddr_r      <= 4'h0;
            wByte_r       <= 8'h00;
            wLane_r       <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awAddr_r      <= s_axi_awaddr;
            end else if (wrFire) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wByte_r      <= s_axi_wdata[7:0];
                wLane_r      <= s_axi_wstrb[0];
            end else if (wrFire) begin
                s_axi_wready <= 1'b1;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? qstod_pkg::RESP_OKAY
                                         : qstod_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi4-lite read channels
    assign statusByte = {flags_r, ie_r, cmpEn_r, pending};
    assign rdMapped = (s_axi_araddr == qstod_pkg::OFS_CONTROL)
                    | (s_axi_araddr == qstod_pkg::OFS_STATUS)
                    | (s_axi_araddr == qstod_pkg::OFS_MATCH)
                    | (s_axi_araddr == qstod_pkg::OFS_COUNT);
    // the clear bit always reads back as zero
    assign rdMux = (s_axi_araddr == qstod_pkg::OFS_CONTROL)
                 ? {ctrl_r.enable, ctrl_r.source, 2'h0, ctrl_r.prescale}
                 : (s_axi_araddr == qstod_pkg::OFS_STATUS) ? statusByte
                 : (s_axi_araddr == qstod_pkg::OFS_MATCH)
                 ? {cmpValue_r, cmpSnap_r}
                 : (s_axi_araddr == qstod_pkg::OFS_COUNT) ? cnt_r
                 : 8'h00;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= qstod_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h0, rdMux};
                s_axi_rresp   <= rdMapped ? qstod_pkg::RESP_OKAY
                                          : qstod_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b0;
            end
        end
    end

    // ==========================================================
    // checks
    property p_qtick_flag;
        tick |=> flags_r.qtick;
    endproperty
    a_qtick_flag: assert property (p_qtick_flag)
        else $error("quarter flag not set after tick");

    property p_sec_flag;
        tick && (cntInc[1:0] == 2'h0) |=> flags_r.second
            ##1 (irqReq || !$past(ie_r.second));
    endproperty
    a_sec_flag: assert property (p_sec_flag)
        else $error("second flag or its interrupt missing");

    property p_count_step;
        tick && !matchHit && !clearReq |=> cnt_r == 8'($past(cnt_r) + 8'h01);
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step by one on tick");

    property p_disabled_zero;
        !ctrl_r.enable |=> cnt_r == 8'h00 && div_r == 22'h0;
    endproperty
    a_disabled_zero: assert property (p_disabled_zero)
        else $error("counter not held at zero while disabled");

    property p_clear;
        clearReq |=> cnt_r == 8'h00 && div_r == 22'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter clear did not zero counter and divider");

    property p_match_zero;
        matchHit && !clearReq |=> cnt_r[7:2] == 6'h00 && flags_r.hit
            && cnt_r[1:0] == $past(cntInc[1:0]);
    endproperty
    a_match_zero: assert property (p_match_zero)
        else $error("match did not zero upper counter bits");

    property p_match_gate;
        !cmpEn_r |-> !matchHit ##1 !compareHitOut;
    endproperty
    a_match_gate: assert property (p_match_gate)
        else $error("match raised while compare disabled");

    property p_hit_pulse;
        matchHit |=> compareHitOut ##1 !compareHitOut;
    endproperty
    a_hit_pulse: assert property (p_hit_pulse)
        else $error("match output not a single pulse");

    property p_pending;
        wrMatch && !pending |=> pending ##[1:3] !pending;
    endproperty
    a_pending: assert property (p_pending)
        else $error("write pending bit timing wrong");

    property p_ignore;
        wrMatch && pending |=> $stable(cmpValue_r) && $stable(cmpSnap_r);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("match write taken while pending");

    property p_irq;
        |(flags_r & ie_r) |=> irqReq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing for enabled flag");

endmodule : qstod_counter

// ---- dv/qstod_counter_tb.sv ----
// Purpose: register-level test of the quarter-second time-of-day counter
// Assumes: oscillator divider shortened to 4, so a tick is 32 core cycles
// Notes:   handshakes sampled at the rising edge; bready and rready stay high
module qstod_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // signals
    logic        core_clk;
    logic        rst;
    logic [7:0]  refDiv;
    logic        oscRefIn, lowPowerOscIn, intRefIn;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, hitOut, irqReq;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rr;
    int          mismatches, checksDone, cycles, hitPulses;

    qstod_counter #(.DIV_32K768(22'h000004)) qstod_counter_inst (
        .core_clk(core_clk), .rst(rst), .oscRefIn(oscRefIn),
        .lowPowerOscIn(lowPowerOscIn), .intRefIn(intRefIn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .compareHitOut(hitOut), .irqReq(irqReq));

    // ==========================================================
    // clock, references, watchdog
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // references stay well below half of core_clk so none is missed
    always @(posedge core_clk) begin
        refDiv <= refDiv + 8'h01;
        oscRefIn <= refDiv[2];
        intRefIn <= refDiv[3];
        lowPowerOscIn <= refDiv[4];
        cycles <= cycles + 1;
        if (rst) hitPulses <= 0;
        else if (hitOut) hitPulses <= hitPulses + 1;
        if (cycles == 60000) begin
            mismatches++;
            final_report();
        end
    end

    // ==========================================================
    // bus tasks
    task automatic chk(input string nm, input logic [31:0] e, got);
        checksDone++;
        if (got !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    // called just after a rising edge; values read here are pre-edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic b;
        b = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!b) begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            b = bvalid;
        end
        chk("bresp", 32'(qstod_pkg::RESP_OKAY), 32'(bresp));
    endtask : wr

    task automatic rdr(input logic [3:0] a);
        logic r;
        r = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!r) begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            r = rvalid;
            rd = rdata;
            rr = rresp;
        end
    endtask : rdr

    // reads until the masked value appears; a stall counts as a mismatch
    task automatic poll(input logic [3:0] a, input logic [7:0] m, v);
        int n;
        n = 0;
        do begin
            rdr(a);
            n++;
        end while ((rd[7:0] & m) !== v && n < 5000);
        chk("poll", 32'(v), 32'(rd[7:0] & m));
    endtask : poll

    task automatic final_report();
        if (mismatches == 0 && checksDone > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // tests
    initial begin
        rst = 1'b1;
        refDiv = 8'h00;
        {oscRefIn, lowPowerOscIn, intRefIn} = 3'b000;
        {awvalid, wvalid, arvalid} = 3'b000;
        {bready, rready} = 2'b11;
        wstrb = 4'hf;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h00000000;
        {mismatches, checksDone, cycles} = 3'b000;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rdr(qstod_pkg::OFS_CONTROL); chk("control", 32'h01, rd);
        rdr(qstod_pkg::OFS_STATUS); chk("status", 32'h00, rd);
        rdr(qstod_pkg::OFS_COUNT); chk("count", 32'h00, rd);
        rdr(4'h2); chk("rresp", 32'(qstod_pkg::RESP_SLVERR), 32'(rr));
        wr(qstod_pkg::OFS_STATUS, 8'h18);
        wr(qstod_pkg::OFS_CONTROL, 8'h81);
        poll(qstod_pkg::OFS_COUNT, 8'hff, 8'h01);
        rdr(qstod_pkg::OFS_STATUS); chk("qtick", 32'h1, 32'(rd[7]));
        chk("irqReq", 32'h1, 32'(irqReq));
        wr(qstod_pkg::OFS_STATUS, 8'h98);
        rdr(qstod_pkg::OFS_STATUS); chk("qtickClr", 32'h0, 32'(rd[7]));
        poll(qstod_pkg::OFS_COUNT, 8'hff, 8'h04);
        rdr(qstod_pkg::OFS_STATUS); chk("second", 32'h1, 32'(rd[6]));
        poll(qstod_pkg::OFS_COUNT, 8'hff, 8'hff);
        poll(qstod_pkg::OFS_COUNT, 8'hff, 8'h00);
        // match value 0 would hit at the wrap if compare were enabled
        rdr(qstod_pkg::OFS_STATUS); chk("noHit", 32'h0, 32'(rd[5]));
        wr(qstod_pkg::OFS_CONTROL, 8'h91);
        rdr(qstod_pkg::OFS_COUNT); chk("cleared", 32'h00, rd);
        rdr(qstod_pkg::OFS_CONTROL); chk("ctlRead", 32'h81, rd);
        // a write with lane 0 off must leave the register alone
        wstrb <= 4'h0;
        wr(qstod_pkg::OFS_CONTROL, 8'h01);
        wstrb <= 4'hf;
        rdr(qstod_pkg::OFS_CONTROL); chk("strobeOff", 32'h81, rd);
        wr(qstod_pkg::OFS_CONTROL, 8'h01);
        repeat (100) @(posedge core_clk);
        rdr(qstod_pkg::OFS_COUNT); chk("held", 32'h00, rd);
        wr(qstod_pkg::OFS_STATUS, 8'he6);
        wr(qstod_pkg::OFS_MATCH, 8'h07);
        rdr(qstod_pkg::OFS_STATUS); chk("pendSet", 32'h1, 32'(rd[0]));
        rdr(qstod_pkg::OFS_STATUS); chk("pendDone", 32'h0, 32'(rd[0]));
        wr(qstod_pkg::OFS_MATCH, 8'h07);
        // issued at once, so it lands while the first is still pending
        wr(qstod_pkg::OFS_MATCH, 8'h0b);
        rdr(qstod_pkg::OFS_MATCH); chk("match", 32'h04, rd);
        chk("hitIdle", 32'h0, 32'(hitPulses));
        wr(qstod_pkg::OFS_CONTROL, 8'h81);
        poll(qstod_pkg::OFS_STATUS, 8'h20, 8'h20);
        rdr(qstod_pkg::OFS_COUNT); chk("upper", 32'h0, 32'(rd[7:2]));
        chk("hitPulses", 32'h1, 32'(hitPulses));
        chk("irqHit", 32'h1, 32'(irqReq));
        wr(qstod_pkg::OFS_STATUS, 8'he6);
        repeat (2) @(posedge core_clk);
        chk("irqClr", 32'h0, 32'(irqReq));
        // source and prescale change only while the module is off
        wr(qstod_pkg::OFS_CONTROL, 8'h01);
        wr(qstod_pkg::OFS_CONTROL, 8'h41);
        wr(qstod_pkg::OFS_CONTROL, 8'hc1);
        poll(qstod_pkg::OFS_COUNT, 8'hff, 8'h01);
        wr(qstod_pkg::OFS_CONTROL, 8'h41);
        wr(qstod_pkg::OFS_CONTROL, 8'h20);
        wr(qstod_pkg::OFS_CONTROL, 8'ha0);
        poll(qstod_pkg::OFS_COUNT, 8'hff, 8'h01);
        final_report();
    end
endmodule : qstod_counter_tb
